// ### hdl/drive_activity_led_control.sv
`timescale 1ns/100ps
`include "dal_cfg.svh"
// activity indicator driver; status inputs are from other clock domains
module drive_activity_led_control
	import dal_pkg::*;
#(
	parameter int HALF_CYC = `DAL_BLINK_CYC
)
(
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic spunUp,
	input  wire logic spinTransition,
	input  wire logic cmdActive,
	input  wire logic formatActive,
	input  wire logic cylinderChange,
	input  wire logic indicator_polarity_select,
	input  wire logic indicatorOutputIn,
	output logic      indicatorOutputOut,
	output logic      indicatorOutputOe
);
	logic       rstMeta;
	logic       rstN;
	logic [5:0] syncA;
	logic [5:0] syncB;
	logic       cylPrev_reg;
	logic       cylPrev_next;
	logic       fmtLed_reg;
	logic       fmtLed_next;
	logic       ledOn_reg;
	logic       ledOn_next;
	logic       blinkPhase;
	dal_mode_type mode;
	logic       sUp;
	logic       sSpin;
	logic       sCmd;
	logic       sFmt;
	logic       sCyl;
	logic       sPol;
	logic [`DAL_CNT_W-1:0] runCnt_reg;
	logic [`DAL_CNT_W-1:0] runCnt_next;

	// steady level: spun down follows activity, spun up also polarity
	function automatic logic steadyLevel
	(
		input logic up,
		input logic busy,
		input logic pol
	);
		if (!up)
			return busy;
		return busy ? pol : ~pol;
	endfunction

	// reset release through two flip-flops
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// two-stage synchronisers for all status inputs
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			syncA <= '0;
			syncB <= '0;
		end
		else
		begin
			syncA <= {spunUp, spinTransition, cmdActive, formatActive,
				cylinderChange, indicator_polarity_select};
			syncB <= syncA;
		end
	end
	assign {sUp, sSpin, sCmd, sFmt, sCyl, sPol} = syncB;

	// mode priority: format, then spin blink, then steady
	always_comb
	begin
		if (sFmt)
			mode = DAL_FORMAT;
		else if (sSpin)
			mode = DAL_SPINNING;
		else if (sUp)
			mode = DAL_SPUN_UP;
		else
			mode = DAL_SPUN_DOWN;
	end

	dal_blink_timer #(
		.HALF_CYC (HALF_CYC)
	) uBlink (
		.mclk   (mclk),
		.rstN   (rstN),
		.enable (mode == DAL_SPINNING),
		.phase  (blinkPhase)
	);

	// indicator level selection and format toggle state
	always_comb
	begin
		cylPrev_next = sCyl;
		fmtLed_next  = fmtLed_reg;
		ledOn_next   = ledOn_reg;
		if (mode != DAL_FORMAT)
			fmtLed_next = ledOn_reg;
		else if (sCyl && !cylPrev_reg)
			fmtLed_next = ~fmtLed_reg;
		case (mode)
			DAL_FORMAT:    ledOn_next = fmtLed_next;
			DAL_SPINNING:  ledOn_next = blinkPhase;
			DAL_SPUN_UP:   ledOn_next = steadyLevel(1'h1, sCmd, sPol);
			DAL_SPUN_DOWN: ledOn_next = steadyLevel(1'h0, sCmd, sPol);
			default:       ledOn_next = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			cylPrev_reg <= 1'b0;
			fmtLed_reg  <= 1'b0;
			ledOn_reg   <= 1'b0;
		end
		else
		begin
			cylPrev_reg <= cylPrev_next;
			fmtLed_reg  <= fmtLed_next;
			ledOn_reg   <= ledOn_next;
		end
	end

	// assertion helper: length of the current blink run
	always_comb
	begin
		if (mode != DAL_SPINNING || ledOn_next != ledOn_reg)
			runCnt_next = '0;
		else
			runCnt_next = runCnt_reg + `DAL_CNT_W'(1);
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			runCnt_reg <= '0;
		else
			runCnt_reg <= runCnt_next;
	end

	// open drain: drive low only when lit
	assign indicatorOutputOut = 1'b0;
	assign indicatorOutputOe  = ledOn_reg;

	logic unusedIn;
	assign unusedIn = indicatorOutputIn;

	// named steps of the blink and format behaviours
	sequence s_spinEntry;
		$rose(mode == DAL_SPINNING);
	endsequence
	sequence s_fmtCylEdge;
		mode == DAL_FORMAT && $past(mode) == DAL_FORMAT
		&& sCyl && !cylPrev_reg;
	endsequence
	sequence s_fmtNoEdge;
		mode == DAL_FORMAT && $past(mode) == DAL_FORMAT
		&& !(sCyl && !cylPrev_reg);
	endsequence

	// steady states one cycle after the mode is sampled
	AST_DOWN_IDLE_OFF: assert property (@(posedge mclk)
		disable iff (!rstN)
		($past(mode) == DAL_SPUN_DOWN && !$past(sCmd)) |-> !indicatorOutputOe)
		else $error("spun down idle but lit");
	AST_DOWN_BUSY_ON: assert property (@(posedge mclk)
		disable iff (!rstN)
		($past(mode) == DAL_SPUN_DOWN && $past(sCmd)) |-> indicatorOutputOe)
		else $error("spun down busy but dark");
	AST_UP_IDLE: assert property (@(posedge mclk)
		disable iff (!rstN)
		($past(mode) == DAL_SPUN_UP && !$past(sCmd))
		|-> indicatorOutputOe == !$past(sPol))
		else $error("spun up idle level wrong");
	AST_UP_BUSY: assert property (@(posedge mclk)
		disable iff (!rstN)
		($past(mode) == DAL_SPUN_UP && $past(sCmd))
		|-> indicatorOutputOe == $past(sPol))
		else $error("spun up busy level wrong");

	// blink: lit on entry, no run longer than half a period
	AST_BLINK_ON_START: assert property (@(posedge mclk)
		disable iff (!rstN)
		s_spinEntry |=> indicatorOutputOe)
		else $error("blink not lit at start");
	AST_BLINK_RUN: assert property (@(posedge mclk)
		disable iff (!rstN)
		runCnt_reg <= `DAL_CNT_W'(HALF_CYC))
		else $error("blink run longer than half period");

	// format: a cylinder edge flips the level, otherwise it holds
	AST_FMT_TOGGLE: assert property (@(posedge mclk)
		disable iff (!rstN)
		s_fmtCylEdge |=> indicatorOutputOe != $past(indicatorOutputOe))
		else $error("no toggle on cylinder change");
	AST_FMT_HOLD: assert property (@(posedge mclk)
		disable iff (!rstN)
		s_fmtNoEdge |=> $stable(indicatorOutputOe))
		else $error("format level moved without cylinder change");
	AST_PRIO: assert property (@(posedge mclk)
		disable iff (!rstN)
		(sFmt && sSpin) |-> mode == DAL_FORMAT)
		else $error("format lost priority");

	// open drain never drives the line high
	AST_OD_LOW: assert property (@(posedge mclk)
		disable iff (!rstN)
		indicatorOutputOe |-> !indicatorOutputOut)
		else $error("open drain drives high");
endmodule // drive_activity_led_control

// ### hdl/dal_cfg.svh
`ifndef DAL_CFG_SVH
`define DAL_CFG_SVH
`define DAL_CLK_HZ      10000000
`define DAL_BLINK_MS    500
`define DAL_BLINK_CYC   ((`DAL_CLK_HZ / 1000) * `DAL_BLINK_MS)
`define DAL_CNT_W       23
`endif

// ### hdl/dal_pkg.sv
package dal_pkg;
	typedef enum logic [1:0]
	{
		DAL_SPUN_DOWN,
		DAL_SPUN_UP,
		DAL_SPINNING,
		DAL_FORMAT
	} dal_mode_type;
endpackage

// ### hdl/dal_blink_timer.sv
`timescale 1ns/100ps
`include "dal_cfg.svh"
// half-period timer: toggles phase every blink interval while enabled
module dal_blink_timer
	import dal_pkg::*;
#(
	parameter int HALF_CYC = `DAL_BLINK_CYC
)
(
	input  wire logic mclk,
	input  wire logic rstN,
	input  wire logic enable,
	output logic      phase
);
	logic [`DAL_CNT_W-1:0] cnt_reg;
	logic [`DAL_CNT_W-1:0] cnt_next;
	logic                  phase_reg;
	logic                  phase_next;

	// count down one half period, restart lit when disabled
	always_comb
	begin
		cnt_next   = cnt_reg;
		phase_next = phase_reg;
		if (!enable)
		begin
			cnt_next   = `DAL_CNT_W'(HALF_CYC - 1);
			phase_next = 1'b1;
		end
		else if (cnt_reg == '0)
		begin
			cnt_next   = `DAL_CNT_W'(HALF_CYC - 1);
			phase_next = ~phase_reg;
		end
		else
			cnt_next = cnt_reg - `DAL_CNT_W'(1);
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			cnt_reg   <= '0;
			phase_reg <= 1'b1;
		end
		else
		begin
			cnt_reg   <= cnt_next;
			phase_reg <= phase_next;
		end
	end

	assign phase = phase_reg;
endmodule // dal_blink_timer

// ### sim/dal_led_model.sv
`timescale 1ns/100ps
// led and resistor to the supply; line floats high when released
module dal_led_model
(
	input  wire logic pinOe,
	input  wire logic pinOut,
	output logic      pinLevel,
	output logic      ledLit
);
	// pull-up wins unless the pin is pulled low
	assign pinLevel = pinOe ? pinOut : 1'b1;
	assign ledLit   = ~pinLevel;
endmodule // dal_led_model

// ### sim/drive_activity_led_control_tb.sv
`timescale 1ns/100ps
module drive_activity_led_control_tb;
	localparam int HALF = 8;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic up = 1'b0, spin = 1'b0, cmd = 1'b0;
	logic fmt = 1'b0, cyl = 1'b0, pol = 1'b0;
	logic pinOut, pinOe, pin, lit;
	int fails = 0, n_compared = 0, cyc = 0, i, n;
	int seed = 32'h22F1BFC5;
	// clock at 10 MHz
	always #50 mclk = ~mclk;
	drive_activity_led_control #(.HALF_CYC(HALF)) dut_u
	(
		.mclk(mclk), .nrst(nrst), .spunUp(up), .spinTransition(spin),
		.cmdActive(cmd), .formatActive(fmt), .cylinderChange(cyl),
		.indicator_polarity_select(pol), .indicatorOutputIn(pin),
		.indicatorOutputOut(pinOut), .indicatorOutputOe(pinOe)
	);
	dal_led_model led_u
	(
		.pinOe(pinOe), .pinOut(pinOut), .pinLevel(pin), .ledLit(lit)
	);
	// compare one value and count it
	task automatic check(input string what, input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	// rule model of the steady indicator level
	function automatic logic model(input int u, input int c, input int p);
		if (u == 0)
			return logic'(c != 0);
		return logic'(c == p);
	endfunction
	task automatic waitc(input int k);
		repeat (k) @(negedge mclk);
	endtask
	// length of the current run of one led level, bounded
	task automatic runLen(input logic lvl, output int len);
		len = 0;
		while (lit === lvl && len < 40)
		begin
			waitc(1);
			len++;
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			end_of_test();
		end
	end
	// main sequence
	initial
	begin
		waitc(12);
		nrst = 1'b1;
		waitc(2);
		// steady states: every combination, then random ones
		for (i = 0; i < 24; i++)
		begin
			{up, cmd, pol} = (i < 8) ? i[2:0] : 3'($random(seed));
			waitc(5);
			check("steady", lit, model(up, cmd, pol));
		end
		$display("steady states done");
		spin = 1'b1;
		waitc(5);
		check("blink start", lit, 1'b1);
		runLen(1'b1, n);
		runLen(1'b0, n);
		check("blink off time", n == HALF, 1'b1);
		runLen(1'b1, n);
		check("blink on time", n == HALF, 1'b1);
		$display("blink done");
		spin = 1'b0;
		{up, cmd, pol} = 3'h4;
		waitc(5);
		fmt = 1'b1;
		spin = 1'b1;
		waitc(5);
		// format toggles from the lit level, spin blinking held off
		for (i = 1; i < 5; i++)
		begin
			cyl = 1'b1;
			waitc(2);
			cyl = 1'b0;
			waitc(3 + 4 * i);
			check("format toggle", lit, ~i[0]);
		end
		fmt = 1'b0;
		spin = 1'b0;
		waitc(5);
		check("after format", lit, 1'b1);
		$display("format done");
		// reset in mid-run: dark at once, steady level back after release
		nrst = 1'b0;
		waitc(2);
		check("reset dark", lit, 1'b0);
		nrst = 1'b1;
		waitc(6);
		check("after reset", lit, model(up, cmd, pol));
		$display("reset done");
		end_of_test();
	end
endmodule // drive_activity_led_control_tb
